//--- design/sst_edge_sync.sv
`default_nettype none
module sst_edge_sync
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two-flop synchroniser, then a registered rising-edge detect on the clean copy
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      rise_o <= sync_reg & ~last_reg;
    end
  end
endmodule
`default_nettype wire

//--- design/sst_pkg.sv
`default_nettype none
package sst_pkg;
  // channel organisation: two groups of four, lowest channel of each group is master
  localparam int CH_NUM = 8;
  localparam int GRP_SIZE = 4;
  localparam int CNT_W = 16;
  localparam int FFCR_W = 6;
  localparam int IM_W = 3;
  localparam int TEN_W = 4;

  // prescaler tap 1: counter advances once every two clocks
  localparam int PRE_W = 2;
  localparam logic [PRE_W-1:0] PRE_LAST = 2'h1;
  localparam logic [PRE_W-1:0] PRE_RST = 2'h0;

  // values after reset, and the top of the counter range
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [TEN_W-1:0] TEN_RST = 4'h0;
  localparam logic FF_RST = 1'b0;

  // flip-flop control word: [1:0] action, [5:2] inversion trigger enables
  localparam int FF_ACT_LSB = 0;
  localparam int TEN_LSB = 2;
  localparam int TEN_M0 = 0;
  localparam int TEN_M1 = 1;
  localparam int TEN_C0 = 2;
  localparam int TEN_C1 = 3;
  localparam logic [1:0] FF_ACT_INV = 2'h0;
  localparam logic [1:0] FF_ACT_SET = 2'h1;
  localparam logic [1:0] FF_ACT_CLR = 2'h2;
  localparam logic [1:0] FF_ACT_KEEP = 2'h3;
  localparam logic [FFCR_W-1:0] FFCR_CLEAR = 6'h02;

  // interrupt mask bits, 1 suppresses the source
  localparam int IM_M0 = 0;
  localparam int IM_M1 = 1;
  localparam int IM_OVF = 2;
endpackage
`default_nettype wire

//--- design/sst_timer.sv
`default_nettype none
module sst_timer
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [sst_pkg::CH_NUM-1:0] timer_enable_i,
  input wire logic [sst_pkg::CH_NUM-1:0] counter_run_i,
  input wire logic [sst_pkg::CH_NUM-1:0] prescaler_run_i,
  input wire logic [sst_pkg::CH_NUM-1:0] sync_start_sel_i,
  input wire logic [sst_pkg::CH_NUM-1:0] capture_en_i,
  input wire logic [sst_pkg::CH_NUM-1:0] capture_input_pin_i,
  input wire logic [sst_pkg::CH_NUM*sst_pkg::CNT_W-1:0] compare_reg0_i,
  input wire logic [sst_pkg::CH_NUM*sst_pkg::CNT_W-1:0] compare_reg1_i,
  input wire logic [sst_pkg::CH_NUM-1:0] ffcr_wr_i,
  input wire logic [sst_pkg::CH_NUM*sst_pkg::FFCR_W-1:0] ffcr_wdata_i,
  input wire logic [sst_pkg::CH_NUM*sst_pkg::IM_W-1:0] irq_mask_i,
  input wire logic [sst_pkg::CH_NUM-1:0] port_function_sel_i,
  output logic [sst_pkg::CH_NUM*sst_pkg::CNT_W-1:0] up_counter_o,
  output logic [sst_pkg::CH_NUM*sst_pkg::CNT_W-1:0] capture_reg0_o,
  output logic [sst_pkg::CH_NUM*sst_pkg::TEN_W-1:0] toggle_en_o,
  output logic [sst_pkg::CH_NUM-1:0] output_flipflop_o,
  output logic [sst_pkg::CH_NUM-1:0] timer_output_pin_o,
  output logic [sst_pkg::CH_NUM-1:0] capture0_irq_o,
  output logic [sst_pkg::CH_NUM-1:0] compare_match_irq_o
);
  import sst_pkg::*;

  // counter step, wraps at the top of the 16-bit range
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] v);
    cnt_step = v + 16'h0001;
  endfunction

  // index of the master channel of the group that holds channel ch
  function automatic int master_of(input int ch);
    master_of = (ch / GRP_SIZE) * GRP_SIZE;
  endfunction

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic [CH_NUM-1:0] own_run;
  logic [CH_NUM-1:0] run_eff;
  logic [CH_NUM-1:0] tick;
  logic [CH_NUM-1:0] cap_rise;
  logic [CH_NUM-1:0] cap_evt;
  logic [CH_NUM-1:0] match0;
  logic [CH_NUM-1:0] match1;
  logic [CH_NUM-1:0] wrap;
  logic [CH_NUM-1:0] flip;
  logic [PRE_W-1:0] pre_reg [CH_NUM];
  logic [CNT_W-1:0] cnt_reg [CH_NUM];
  logic [CNT_W-1:0] cap_reg [CH_NUM];
  logic [TEN_W-1:0] ten_reg [CH_NUM];
  logic [CH_NUM-1:0] ff_reg;
  logic [CH_NUM-1:0] ff_next;
  logic [CH_NUM-1:0] pin_reg;
  logic [CH_NUM-1:0] cap_irq_reg;
  logic [CH_NUM-1:0] cmp_irq_reg;

  genvar gi;
  generate
    for (gi = 0; gi < CH_NUM; gi = gi + 1)
    begin : g_ch
      localparam int MST = master_of(gi);
      localparam bit IS_MST = (MST == gi);
      wire logic [CNT_W-1:0] rg0 = compare_reg0_i[gi*CNT_W +: CNT_W];
      wire logic [CNT_W-1:0] rg1 = compare_reg1_i[gi*CNT_W +: CNT_W];
      wire logic [FFCR_W-1:0] ffcr = ffcr_wdata_i[gi*FFCR_W +: FFCR_W];
      wire logic [IM_W-1:0] mask = irq_mask_i[gi*IM_W +: IM_W];
      wire logic [1:0] act = ffcr[FF_ACT_LSB +: 2];
      wire logic [CNT_W-1:0] cnt_inc = cnt_step(cnt_reg[gi]);

      // the capture pin comes from outside the clock domain
      sst_edge_sync u_cap_sync
      (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(capture_input_pin_i[gi]),
        .rise_o(cap_rise[gi])
      );

      // run decode; a master ignores its own sync bit, so a stray 1 there cannot deadlock it
      assign own_run[gi] = timer_enable_i[gi] & counter_run_i[gi] & prescaler_run_i[gi];
      if (IS_MST)
      begin : g_mst
        assign run_eff[gi] = own_run[gi];
      end
      else
      begin : g_slv
        // a synced slave takes the master's run directly, so both leave reset state together
        assign run_eff[gi] = sync_start_sel_i[gi] ? run_eff[MST] : own_run[gi];
      end

      // prescaler tap and compare decode; matches fire on the edge that loads the new count
      assign tick[gi] = run_eff[gi] & (pre_reg[gi] == PRE_LAST);
      assign match0[gi] = tick[gi] & (cnt_inc == rg0);
      assign match1[gi] = tick[gi] & (cnt_inc == rg1);
      assign wrap[gi] = tick[gi] & (cnt_reg[gi] == CNT_MAX);
      assign cap_evt[gi] = cap_rise[gi] & capture_en_i[gi];

      // simultaneous triggers combine as parity, each one inverts once
      assign flip[gi] = (match0[gi] & ten_reg[gi][TEN_M0]) ^ (match1[gi] & ten_reg[gi][TEN_M1])
                      ^ (cap_evt[gi] & ten_reg[gi][TEN_C0]);
      // a control write takes priority over any trigger in the same cycle
      assign ff_next[gi] = !ffcr_wr_i[gi] ? ff_reg[gi] ^ flip[gi] :
                           (act == FF_ACT_INV) ? ~ff_reg[gi] :
                           (act == FF_ACT_SET) ? 1'b1 :
                           (act == FF_ACT_CLR) ? 1'b0 : ff_reg[gi];

      // prescaler and counter are held clear while stopped
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i || !run_eff[gi])
        begin
          pre_reg[gi] <= PRE_RST;
          cnt_reg[gi] <= CNT_RST;
        end
        else
        begin
          pre_reg[gi] <= tick[gi] ? PRE_RST : pre_reg[gi] + 2'h1;
          cnt_reg[gi] <= tick[gi] ? cnt_inc : cnt_reg[gi];
        end
      end

      // capture latch; the value stays put between edges so software may read it late
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
          cap_reg[gi] <= CNT_RST;
        else if (cap_evt[gi])
          cap_reg[gi] <= cnt_reg[gi];
      end

      // trigger enables and output flip-flop
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          ten_reg[gi] <= TEN_RST;
          ff_reg[gi] <= FF_RST;
        end
        else
        begin
          ten_reg[gi] <= ffcr_wr_i[gi] ? ffcr[TEN_LSB +: TEN_W] : ten_reg[gi];
          ff_reg[gi] <= ff_next[gi];
        end
      end

      // interrupt pulses and pin drive; registered so no output glitches on decode
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          cap_irq_reg[gi] <= 1'b0;
          cmp_irq_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end
        else
        begin
          cap_irq_reg[gi] <= cap_evt[gi];
          cmp_irq_reg[gi] <= (match0[gi] & ~mask[IM_M0]) | (match1[gi] & ~mask[IM_M1])
                           | (wrap[gi] & ~mask[IM_OVF]);
          pin_reg[gi] <= port_function_sel_i[gi] & ff_reg[gi];
        end
      end

      // output wiring, every bit straight from a flip-flop
      assign up_counter_o[gi*CNT_W +: CNT_W] = cnt_reg[gi];
      assign capture_reg0_o[gi*CNT_W +: CNT_W] = cap_reg[gi];
      assign toggle_en_o[gi*TEN_W +: TEN_W] = ten_reg[gi];
      assign output_flipflop_o[gi] = ff_reg[gi];
      assign timer_output_pin_o[gi] = pin_reg[gi];
      assign capture0_irq_o[gi] = cap_irq_reg[gi];
      assign compare_match_irq_o[gi] = cmp_irq_reg[gi];

      // checks on channel behaviour
      // a master with its own run bits low stays clear, whatever its sync bit says
      property p_master_alone;
        (IS_MST && !own_run[gi]) |=> (cnt_reg[gi] == CNT_RST);
      endproperty
      a_master_alone: assert property (p_master_alone) else $error("master run not own run");

      property p_independent;
        (!IS_MST && !sync_start_sel_i[gi] && !own_run[gi]) |=> (cnt_reg[gi] == CNT_RST);
      endproperty
      a_independent: assert property (p_independent) else $error("unsynced channel run mismatch");

      property p_sync_start;
        (!IS_MST && sync_start_sel_i[gi] && $rose(run_eff[MST]))
          |-> run_eff[gi] ##1 (pre_reg[gi] == pre_reg[MST]);
      endproperty
      a_sync_start: assert property (p_sync_start) else $error("slave did not start with master");

      property p_capture;
        cap_evt[gi] |=> (cap_reg[gi] == $past(cnt_reg[gi])) && capture0_irq_o[gi];
      endproperty
      a_capture: assert property (p_capture) else $error("capture value or interrupt wrong");

      property p_cap_irq_only;
        !cap_evt[gi] |=> !capture0_irq_o[gi];
      endproperty
      a_cap_irq_only: assert property (p_cap_irq_only) else $error("spurious capture interrupt");

      property p_cap_hold;
        !cap_evt[gi] |=> $stable(cap_reg[gi]);
      endproperty
      a_cap_hold: assert property (p_cap_hold) else $error("capture register changed without edge");

      property p_match_toggle;
        (!ffcr_wr_i[gi] && match1[gi] && !match0[gi] && ten_reg[gi][TEN_M1] && !cap_evt[gi])
          |=> (ff_reg[gi] != $past(ff_reg[gi]));
      endproperty
      a_match_toggle: assert property (p_match_toggle) else $error("no inversion on match");

      property p_cap_toggle;
        (!ffcr_wr_i[gi] && cap_evt[gi] && ten_reg[gi][TEN_C0] && !match0[gi] && !match1[gi])
          |=> (ff_reg[gi] != $past(ff_reg[gi]));
      endproperty
      a_cap_toggle: assert property (p_cap_toggle) else $error("no inversion on capture");

      property p_clear;
        (ffcr_wr_i[gi] && ffcr == FFCR_CLEAR) |=> !ff_reg[gi] && (ten_reg[gi] == TEN_RST);
      endproperty
      a_clear: assert property (p_clear) else $error("clear pattern did not clear");

      property p_mask;
        (match0[gi] && mask[IM_M0] && !match1[gi] && !wrap[gi]) |=> !compare_match_irq_o[gi];
      endproperty
      a_mask: assert property (p_mask) else $error("masked match-0 raised interrupt");

      property p_pin;
        port_function_sel_i[gi] |=> (timer_output_pin_o[gi] == $past(ff_reg[gi]));
      endproperty
      a_pin: assert property (p_pin) else $error("pin does not follow flip-flop");

      property p_wrap;
        wrap[gi] && $past(run_eff[gi]) |=> (cnt_reg[gi] == CNT_RST);
      endproperty
      a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

      // counter, interrupt, pin and trigger-enable checks beyond the main scenarios
      property p_hold;
        (run_eff[gi] && !tick[gi]) |=> $stable(cnt_reg[gi]);
      endproperty
      a_hold: assert property (p_hold) else $error("counter moved between prescaler ticks");

      property p_step;
        tick[gi] |=> ((cnt_reg[gi] - $past(cnt_reg[gi])) == 16'h0001);
      endproperty
      a_step: assert property (p_step) else $error("counter did not advance by one on tick");

      property p_irq_one;
        compare_match_irq_o[gi] |=> !compare_match_irq_o[gi];
      endproperty
      a_irq_one: assert property (p_irq_one) else $error("match interrupt not a pulse");

      property p_cap_irq_one;
        capture0_irq_o[gi] |=> !capture0_irq_o[gi];
      endproperty
      a_cap_irq_one: assert property (p_cap_irq_one) else $error("capture interrupt not a pulse");

      property p_unmasked;
        (match1[gi] && !mask[IM_M1]) |=> compare_match_irq_o[gi];
      endproperty
      a_unmasked: assert property (p_unmasked) else $error("unmasked match-1 raised no interrupt");

      property p_pin_off;
        !port_function_sel_i[gi] |=> !timer_output_pin_o[gi];
      endproperty
      a_pin_off: assert property (p_pin_off) else $error("pin driven while not selected");

      property p_ten_hold;
        !ffcr_wr_i[gi] |=> $stable(ten_reg[gi]);
      endproperty
      a_ten_hold: assert property (p_ten_hold) else $error("trigger enables changed without write");

      c_capture: cover property (cap_evt[gi] ##[1:200] match1[gi]);
      c_sync: cover property (!IS_MST && sync_start_sel_i[gi] && $rose(run_eff[gi]));
      c_wrap: cover property (wrap[gi]);
      c_pulse: cover property ($rose(timer_output_pin_o[gi]) ##[1:300] $fell(timer_output_pin_o[gi]));
      c_clear: cover property (ffcr_wr_i[gi] && (ffcr == FFCR_CLEAR));
    end
  endgenerate
endmodule
`default_nettype wire

//--- tb/sst_pulse_src.sv
`default_nettype none
module sst_pulse_src
(
  input wire logic clk_i,
  input wire logic [7:0] fire_i,
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [8];
  initial pin_o = '0;
  // a shot is high four clocks, then low at least three before another may start,
  // so the synchroniser always sees a clean low gap between rises
  always @(posedge clk_i)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (fire_i[i] && cnt[i] == 0) cnt[i] <= 6;
      else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      pin_o[i] <= cnt[i] > 3 || (fire_i[i] && cnt[i] == 0);
    end
  end
endmodule
`default_nettype wire

//--- tb/sst_timer_tb.sv
`default_nettype none
module sst_timer_tb import sst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, sys_rst_i, on;
  logic [7:0] en, cr, pr, sy, ce, fw, ps, fire, pin, ff, opin, ci, mi;
  logic [127:0] rg0, rg1, uc, cp;
  logic [47:0] fd;
  logic [23:0] im;
  logic [31:0] te;
  int fails, num_checks, seed, v, a;
  int cnt [8], pre [8], cap [8], ten [8], mff [8], mpin [8], mci [8], mmi [8], s1 [8], s2 [8], s3 [8], fl [8];
  bit run [8];
  bit tk, ev, tg;

  sst_pulse_src src (.clk_i(clk_i), .fire_i(fire), .pin_o(pin));
  sst_timer uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .timer_enable_i(en), .counter_run_i(cr),
    .prescaler_run_i(pr), .sync_start_sel_i(sy), .capture_en_i(ce), .capture_input_pin_i(pin),
    .compare_reg0_i(rg0), .compare_reg1_i(rg1), .ffcr_wr_i(fw), .ffcr_wdata_i(fd), .irq_mask_i(im),
    .port_function_sel_i(ps), .up_counter_o(uc), .capture_reg0_o(cp), .toggle_en_o(te),
    .output_flipflop_o(ff), .timer_output_pin_o(opin), .capture0_irq_o(ci), .compare_match_irq_o(mi));

  initial
  begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // reference model; masters are updated first so slaves see the start in the same cycle
  always @(posedge clk_i)
  begin
    for (int i = 0; i < 8; i++)
      run[i] = (i % 4 != 0 && sy[i]) ? run[i - i % 4] : (en[i] && cr[i] && pr[i]);
    for (int i = 0; i < 8; i++)
    begin
      v = (cnt[i] + 1) % 65536;
      tk = run[i] && pre[i] == 1;
      ev = fl[i] && ce[i];
      tg = (tk && v == rg0[i*16+:16] && ten[i][0]) ^ (tk && v == rg1[i*16+:16] && ten[i][1]) ^ (ev && ten[i][2]);
      mci[i] = ev;
      mmi[i] = tk && (v == rg0[i*16+:16] && !im[i*3] || v == rg1[i*16+:16] && !im[i*3+1] || v == 0 && !im[i*3+2]);
      mpin[i] = ps[i] && mff[i];
      if (ev) cap[i] = cnt[i];
      a = fd[i*6+:2];
      // a control write overrides any trigger landing on the same edge
      if (fw[i]) mff[i] = a == 0 ? !mff[i] : a == 1 ? 1 : a == 2 ? 0 : mff[i];
      else mff[i] = mff[i] ^ tg;
      if (fw[i]) ten[i] = fd[i*6+2+:4];
      fl[i] = s2[i] && !s3[i];
      s3[i] = s2[i];
      s2[i] = s1[i];
      s1[i] = pin[i];
      pre[i] = run[i] && !tk;
      cnt[i] = !run[i] ? 0 : tk ? v : cnt[i];
      if (sys_rst_i) {cnt[i], pre[i], cap[i], ten[i], mff[i], mpin[i], mci[i], mmi[i], s1[i], s2[i], s3[i], fl[i]} = '0;
    end
  end

  // outputs compared away from the clock edge, every cycle
  always @(negedge clk_i)
    if (on)
      for (int i = 0; i < 8; i++)
      begin
        chk(uc[i*16+:16], 16'(cnt[i]));
        chk(cp[i*16+:16], 16'(cap[i]));
        chk(te[i*4+:4], 16'(ten[i]));
        chk(ff[i], 16'(mff[i]));
        chk(opin[i], 16'(mpin[i]));
        chk(ci[i], 16'(mci[i]));
        chk(mi[i], 16'(mmi[i]));
      end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    finish_test();
  end

  initial
  begin
    {on, en, cr, pr, sy, ce, fw, ps, fire, fd, im, rg0, rg1} = '0;
    sys_rst_i = 1;
    seed = 95076;
    step(1);
    on = 1;
    step(11);
    sys_rst_i = 0;
    en = '1;
    sy = 8'hee; // masters keep their sync bit low
    ce = 8'h15;
    ps = 8'($random(seed));
    im = 24'($random(seed));
    for (int i = 0; i < 8; i++)
    begin
      a = 3 + $unsigned($random(seed)) % 20;
      rg0[i*16+:16] = 16'(a);
      rg1[i*16+:16] = 16'(a + 1 + $unsigned($random(seed)) % 30);
    end
    // both match toggles on everywhere; channel 2 toggles on capture instead
    fd = {8{6'h0e}};
    fd[17:12] = 6'h12;
    fw = '1;
    step(1);
    fw = '0;
    {cr[0], pr[0]} = 2'h3; // slaves 1-3 get no run bits of their own
    {cr[5], pr[5]} = 2'h3; // slave 5 has its own run bits yet must wait for channel 4
    step(10);
    {cr[4], pr[4]} = 2'h3;
    step(150);
    im[2:0] = 3'h5;
    fire = 8'h07;
    step(1);
    fire = '0;
    step(6);
    // capture handlers: delayed shot on channel 0, undelayed on channel 2
    rg0[15:0] = 16'(cap[0] + 6);
    rg1[15:0] = 16'(cap[0] + 11);
    rg1[47:32] = 16'(cap[2] + 5);
    fd[5:0] = 6'h0f;
    fd[17:12] = 6'h0b;
    fw = 8'h05;
    step(1);
    fw = '0;
    step(40);
    fd[5:0] = 6'h03; // match toggles off once the shot is out
    fd[17:12] = 6'h03;
    fw = 8'h05;
    step(1);
    fd = {8{FFCR_CLEAR}};
    fw = '1;
    step(1);
    fw = '0;
    // random traffic; ch0 and ch4 keep their run bits so slaves keep following
    repeat (60)
    begin
      fd = 48'({$random(seed), $random(seed)});
      fw = 8'($random(seed));
      im = 24'($random(seed));
      ps = 8'($random(seed));
      fire = 8'($random(seed));
      {cr, pr} = 16'($random(seed) | 32'h1111);
      sy = 8'($random(seed)) & 8'hee;
      step(1);
      fw = '0;
      fire = '0;
      step(7);
    end
    sys_rst_i = 1;
    step(2);
    sys_rst_i = 0;
    step(30);
    finish_test();
  end
endmodule
`default_nettype wire
